//--- rtl/hot_swap_pkg.sv
// hot_swap_pkg: register map, field positions, modes and state types for the fault sequencer.
// assumes one 25 MHz clock domain; the command engine outside resolves register codes.
package hot_swap_pkg;

   // register codes as seen by the command engine
   localparam logic [7:0] summary_status_adr = 8'h79;
   localparam logic [7:0] input_fault_status_adr = 8'h7c;
   localparam logic [7:0] vendor_fault_status_adr = 8'h80;
   localparam logic [7:0] alert_suppress_adr = 8'hd8;
   localparam logic [7:0] protection_setup_adr = 8'hd9;
   localparam logic [7:0] diag_summary_adr = 8'he1;

   // reset values of the writable registers
   localparam logic [15:0] alert_suppress_rst = 16'h0000;
   localparam logic [7:0] protection_setup_rst = 8'h00;

   // protection_setup fields
   localparam int ps_cl_ovr = 7;
   localparam int ps_cl_val = 6;
   localparam int ps_cb_ovr = 5;
   localparam int ps_cb_val = 4;
   localparam int ps_retry_lo = 1;

   // retry codes: 0 follows the pin
   localparam logic [2:0] retry_pin = 3'h0;
   localparam logic [2:0] retry_inf = 3'h7;

   // alert_suppress fields
   localparam int as_breaker = 0;
   localparam int as_overcur = 1;
   localparam int as_undervolt = 2;

   // status field positions
   localparam int vf_breaker = 0;
   localparam int if_overcur = 1;
   localparam int if_undervolt = 4;
   localparam int sw_input = 13;
   localparam int dg_breaker = 0;
   localparam int dg_overcur = 1;
   localparam int dg_supply_low = 2;
   localparam int dg_latched = 3;

   // number of full high-to-mid timer cycles before the final ramp
   localparam logic [2:0] retry_cycles = 3'h7;

   typedef enum logic [6:0] {
      st_por = 7'h01,
      st_insert = 7'h02,
      st_uv_off = 7'h04,
      st_on = 7'h08,
      st_limit = 7'h10,
      st_latched = 7'h20,
      st_retry = 7'h40
   } seq_state_t;

   typedef enum logic [1:0] {
      gate_strong_pd = 2'h0,
      gate_weak_pd = 2'h1,
      gate_source = 2'h2,
      gate_regulate = 2'h3
   } gate_mode_t;

   typedef enum logic [2:0] {
      tmr_ground = 3'h0,
      tmr_insert_chg = 3'h1,
      tmr_fault_chg = 3'h2,
      tmr_fast_dis = 3'h3,
      tmr_small_dis = 3'h4
   } timer_mode_t;

   // comparator results and strap pins, all asynchronous to clk
   typedef struct packed {
      logic over_limit;
      logic over_breaker;
      logic over_power;
      logic timer_hi;
      logic timer_mid;
      logic timer_lo;
      logic uv_ok;
      logic limit_select_pin;
      logic breaker_select_pin;
      logic retry_pin_n;
   } analog_in_t;

   // drive selects to the analog front end
   typedef struct packed {
      gate_mode_t gate;
      timer_mode_t timer;
      logic uv_hyst_en;
      logic ov_src_en;
      logic cl_high;
      logic cb_high;
   } drive_t;

endpackage : hot_swap_pkg

//--- rtl/sync_bank.sv
// sync_bank: two-flop synchronisers for a bank of asynchronous levels.
// assumes inputs are slow levels; each bit is synchronised on its own.
`timescale 1ns/100ps
module sync_bank
#(
   parameter int width = 8
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);

   typedef struct packed {
      logic [width-1:0] meta;
      logic [width-1:0] stable;
   } sync_state_t;

   sync_state_t s_q, s_d;

   // first stage is read only by the second
   always_comb
   begin
      s_d.meta = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign sync_out = s_q.stable;

endmodule : sync_bank

//--- rtl/hot_swap_fault_sequencer.sv
// hot_swap_fault_sequencer: breaker, limit timer, latch/retry restart and lockout logic.
// assumes analog comparators and strap pins arrive asynchronously; a command engine
// outside presents register codes with a write strobe and reads reg_rdata one cycle later.
`timescale 1ns/100ps
module hot_swap_fault_sequencer
   import hot_swap_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input analog_in_t analog_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic clear_faults,
   output logic [15:0] reg_rdata,
   output drive_t drive,
   output logic alert_n
);

   // retry budget decode: {unlimited, count}
   function automatic logic [5:0] retry_budget(input logic [2:0] code, input logic pin_n);
      logic [5:0] b;
      b = '0;
      unique case (code)
         retry_pin: b = pin_n ? 6'h00 : 6'h20;
         3'h1: b = 6'h00;
         3'h2: b = 6'h01;
         3'h3: b = 6'h02;
         3'h4: b = 6'h04;
         3'h5: b = 6'h08;
         3'h6: b = 6'h10;
         retry_inf: b = 6'h20;
      endcase
      return b;
   endfunction : retry_budget

   // strap pin unless the setup register overrides it; shared by limit and breaker selects
   function automatic logic strap_pick(input logic ovr_en, input logic ovr_val, input logic pin);
      logic r;
      r = pin;
      if (ovr_en)
         r = ovr_val;
      return r;
   endfunction : strap_pick

   typedef struct packed {
      seq_state_t state;
      logic insert_done;
      logic falling;
      logic [2:0] cycles;
      logic [4:0] retries;
      logic breaker_flag;
      logic overcur_flag;
      logic undervolt_flag;
      logic [15:0] suppress;
      logic [7:0] setup;
      logic [15:0] rdata;
      drive_t drv;
      logic alert_n;
   } core_state_t;

   core_state_t s_q, s_d;
   analog_in_t in_s;
   logic [9:0] in_bits;

   // comparators cross into clk before the sequencer sees them
   sync_bank #(.width(10)) u_sync
   (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(analog_in),
      .sync_out(in_bits)
   );
   assign in_s = analog_in_t'(in_bits);

   // sequencer, flags and register file
   always_comb
   begin
      logic limiting;
      logic [5:0] budget;
      logic may_retry;
      logic latched;
      logic [15:0] sw;
      logic [15:0] dg;
      logic [7:0] inp;
      logic [7:0] vf;
      limiting = in_s.over_limit | in_s.over_power | in_s.over_breaker;
      budget = retry_budget(s_q.setup[ps_retry_lo +: 3], in_s.retry_pin_n);
      may_retry = budget[5] | (s_q.retries < budget[4:0]);
      // locals given values up front so no path leaves them stale
      latched = 1'b0;
      sw = '0;
      dg = '0;
      inp = '0;
      vf = '0;
      s_d = s_q;

      // clear first so that a same-cycle event below wins
      if (clear_faults)
      begin
         s_d.breaker_flag = 1'b0;
         s_d.overcur_flag = 1'b0;
         s_d.undervolt_flag = 1'b0;
      end

      // state walk:
      //   st_por     timer grounded, gate pulled hard until the timer reads empty
      //   st_insert  insertion delay on the timer, gate held by the weak pull-down
      //   st_uv_off  waiting for the lockout input to clear
      //   st_on      gate source on, watching the limit comparators
      //   st_limit   limiting or breaker tripped, fault timer charging
      //   st_latched off until an enable pulse with the timer drained
      //   st_retry   timer cycling between upper and middle levels before the retry
      unique case (s_q.state)
         st_por:
            // timer held at ground until it reads empty
            if (in_s.timer_lo)
               s_d.state = st_insert;
         st_insert:
            if (in_s.timer_hi)
            begin
               s_d.insert_done = 1'b1;
               s_d.state = in_s.uv_ok ? st_on : st_uv_off;
            end
         st_uv_off:
            if (in_s.uv_ok && s_q.insert_done)
               s_d.state = st_on;
         st_on:
            if (limiting)
               s_d.state = st_limit;
         st_limit:
            if (in_s.timer_hi)
            begin
               s_d.overcur_flag = 1'b1;
               s_d.falling = 1'b1;
               s_d.cycles = '0;
               s_d.state = may_retry ? st_retry : st_latched;
            end
            else if (!limiting)
               s_d.state = st_on;
         st_latched:
            // enable pulse honoured only with the timer drained
            if (!in_s.uv_ok && in_s.timer_lo)
            begin
               s_d.retries = '0;
               s_d.state = st_uv_off;
            end
         st_retry:
            if (s_q.falling)
            begin
               if (s_q.cycles == retry_cycles && in_s.timer_lo)
               begin
                  s_d.retries = s_q.retries + 5'h01; // held, not counted, in unlimited use
                  if (budget[5])
                     s_d.retries = s_q.retries;
                  s_d.state = st_on;
               end
               else if (s_q.cycles != retry_cycles && in_s.timer_mid)
                  s_d.falling = 1'b0;
            end
            else if (in_s.timer_hi)
            begin
               s_d.falling = 1'b1;
               s_d.cycles = s_q.cycles + 3'h1;
            end
         default:
            s_d.state = st_por;
      endcase

      // lockout overrides only st_on, st_limit and st_retry, not power-up, insertion or the latch
      if (!in_s.uv_ok && (s_d.state == st_on || s_d.state == st_limit
                          || s_d.state == st_retry))
      begin
         s_d.state = st_uv_off;
         s_d.retries = '0;
      end

      // breaker event flag
      if (in_s.over_breaker && (s_q.state == st_on || s_q.state == st_limit))
         s_d.breaker_flag = 1'b1;
      // under-voltage counts only once powered up
      if (!in_s.uv_ok && s_q.insert_done && s_q.state != st_latched)
         s_d.undervolt_flag = 1'b1;

      latched = (s_d.state == st_latched);

      // drive selects, registered with the state
      s_d.drv.uv_hyst_en = !in_s.uv_ok;
      s_d.drv.ov_src_en = 1'b0; // over-voltage response lives elsewhere
      s_d.drv.cl_high = strap_pick(s_q.setup[ps_cl_ovr], s_q.setup[ps_cl_val],
                                   in_s.limit_select_pin);
      s_d.drv.cb_high = strap_pick(s_q.setup[ps_cb_ovr], s_q.setup[ps_cb_val],
                                   in_s.breaker_select_pin);
      s_d.drv.gate = gate_weak_pd;
      s_d.drv.timer = tmr_fast_dis;
      unique case (s_d.state)
         st_por:
         begin
            s_d.drv.gate = gate_strong_pd;
            s_d.drv.timer = tmr_ground;
         end
         st_insert:
            s_d.drv.timer = tmr_insert_chg;
         st_on:
            s_d.drv.gate = gate_source;
         st_limit:
         begin
            // strong pull-down only while above breaker level
            s_d.drv.gate = in_s.over_breaker ? gate_strong_pd : gate_regulate;
            s_d.drv.timer = tmr_fault_chg;
         end
         st_latched:
            s_d.drv.timer = tmr_small_dis;
         st_retry:
            s_d.drv.timer = s_d.falling ? tmr_small_dis : tmr_fault_chg;
         default:
            s_d.drv.timer = tmr_fast_dis;
      endcase

      // register writes; codes of read-only words fall through untouched,
      // so a stray write from the command engine cannot fake or hide a flag.
      // the written value shows on reg_rdata at the very next edge.
      if (reg_wr)
      begin
         if (reg_addr == alert_suppress_adr)
            s_d.suppress = reg_wdata;
         if (reg_addr == protection_setup_adr)
            s_d.setup = reg_wdata[7:0];
      end

      // status words from the next-cycle flags; built from s_d so a read
      // in the cycle of an event already reports it
      vf = '0;
      vf[vf_breaker] = s_d.breaker_flag;
      inp = '0;
      inp[if_overcur] = s_d.overcur_flag;
      inp[if_undervolt] = s_d.undervolt_flag;
      sw = '0;
      sw[sw_input] = s_d.overcur_flag | s_d.undervolt_flag;
      dg = '0;
      dg[dg_breaker] = s_d.breaker_flag;
      dg[dg_overcur] = s_d.overcur_flag;
      dg[dg_supply_low] = s_d.undervolt_flag;
      dg[dg_latched] = latched;

      unique case (reg_addr)
         summary_status_adr: s_d.rdata = sw;
         input_fault_status_adr: s_d.rdata = {8'h00, inp};
         vendor_fault_status_adr: s_d.rdata = {8'h00, vf};
         alert_suppress_adr: s_d.rdata = s_d.suppress;
         protection_setup_adr: s_d.rdata = {8'h00, s_d.setup};
         diag_summary_adr: s_d.rdata = dg;
         default: s_d.rdata = 16'h0000;
      endcase

      // alert is low while any unsuppressed flag stands
      s_d.alert_n = !((s_d.breaker_flag & !s_d.suppress[as_breaker])
                      | (s_d.overcur_flag & !s_d.suppress[as_overcur])
                      | (s_d.undervolt_flag & !s_d.suppress[as_undervolt]));
   end

   // one register stage for all state and outputs; every output leaves a flop,
   // which costs one cycle of latency but keeps the analog selects glitch free
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s_q <= '0;
         s_q.state <= st_por;
         s_q.suppress <= alert_suppress_rst;
         s_q.setup <= protection_setup_rst;
         s_q.drv.gate <= gate_strong_pd;
         s_q.drv.timer <= tmr_ground;
         s_q.drv.uv_hyst_en <= 1'b1;
         s_q.alert_n <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   assign reg_rdata = s_q.rdata;
   assign drive = s_q.drv;
   assign alert_n = s_q.alert_n;

endmodule : hot_swap_fault_sequencer

//--- test/hot_swap_chk.sv
// hot_swap_chk: port-level assertions for the fault sequencer.
// assumes a bind onto hot_swap_fault_sequencer; analog levels see two sync flops.
`timescale 1ns/100ps
module hot_swap_chk
   import hot_swap_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input analog_in_t analog_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input drive_t drive,
   input wire logic alert_n
);
   logic sup_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // shadow of the breaker suppress bit, so alert checks know when to stay quiet
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         sup_q <= 1'b0;
      else if (reg_wr && reg_addr == alert_suppress_adr)
         sup_q <= reg_wdata[as_breaker];
   end
   breaker_pd_a: assert property (
      $rose(analog_in.over_breaker) && drive.gate == gate_source
      |-> ##[2:4] drive.gate == gate_strong_pd) else $error("breaker did not pull gate");
   breaker_release_a: assert property (
      (drive.gate == gate_strong_pd && drive.timer == tmr_fault_chg
      && !analog_in.over_breaker) [*3] |=> drive.gate != gate_strong_pd)
      else $error("strong pull-down kept after breaker release");
   breaker_alert_a: assert property (
      $rose(drive.gate == gate_strong_pd) && !sup_q |-> ##[0:2] !alert_n)
      else $error("breaker trip without alert");
   power_reg_a: assert property (
      $rose(analog_in.over_power) && drive.gate == gate_source
      |-> ##[2:4] drive.gate == gate_regulate) else $error("power limit not regulating");
   limit_charge_a: assert property (
      drive.gate == gate_regulate |-> drive.timer == tmr_fault_chg)
      else $error("limiting without fault charge");
   recover_dis_a: assert property (
      drive.gate == gate_source && $past(drive.gate) == gate_regulate
      |-> drive.timer == tmr_fast_dis) else $error("recovery without fast discharge");
   timeout_off_a: assert property (
      (drive.gate == gate_regulate && analog_in.timer_hi) [*3]
      |-> ##[1:2] drive.gate == gate_weak_pd) else $error("timeout did not turn off");
   uv_hold_a: assert property (
      (!analog_in.uv_ok) [*5] |-> drive.uv_hyst_en && !drive.ov_src_en
      && drive.gate inside {gate_weak_pd, gate_strong_pd}) else $error("lockout not held");
   uv_hyst_off_a: assert property (
      analog_in.uv_ok [*5] |-> !drive.uv_hyst_en) else $error("hysteresis source left on");
   cover property ($past(drive.gate) == gate_weak_pd && drive.gate == gate_source);
   cover property ($rose(drive.gate == gate_strong_pd));
   cover property (drive.timer == tmr_small_dis && analog_in.timer_lo);
endmodule : hot_swap_chk

bind hot_swap_fault_sequencer hot_swap_chk chk_u (.clk(clk), .rst_b(rst_b),
   .analog_in(analog_in), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .drive(drive), .alert_n(alert_n));

//--- test/fet_timer_model.sv
// fet_timer_model: pass switch, sense resistor and timer capacitor, behavioural.
// assumes drive selects from the sequencer; timer voltage kept in 10 mV steps.
`timescale 1ns/100ps
module fet_timer_model
   import hot_swap_pkg::*;
(
   input wire logic clk,
   input drive_t drive,
   input wire logic fault_cl,
   input wire logic fault_cb,
   input wire logic fault_pw,
   output logic over_limit,
   output logic over_breaker,
   output logic over_power,
   output logic timer_hi,
   output logic timer_mid,
   output logic timer_lo
);
   int v = 0;
   logic on;
   // current only flows while the gate is driven up, so a pull-down ends the fault
   assign on = drive.gate inside {gate_source, gate_regulate};
   assign over_limit = fault_cl && on;
   assign over_breaker = fault_cb && on;
   assign over_power = fault_pw && on;
   assign timer_hi = v >= 170;
   assign timer_mid = v <= 100;
   assign timer_lo = v < 30;
   // capacitor ramps; rates are scaled, only their order matters
   always @(posedge clk)
   begin
      case (drive.timer)
         tmr_insert_chg: v <= (v > 199) ? 200 : v + 1;
         tmr_fault_chg: v <= (v > 196) ? 200 : v + 4;
         tmr_fast_dis: v <= (v < 20) ? 0 : v - 20;
         tmr_small_dis: v <= (v < 1) ? 0 : v - 1;
         default: v <= 0;
      endcase
   end
endmodule : fet_timer_model

//--- test/hot_swap_fault_sequencer_tb.sv
// hot_swap_fault_sequencer_tb: directed scenarios for breaker, limit, retry and lockout.
// assumes fet_timer_model stands in for the switch and the timer capacitor.
`timescale 1ns/100ps
module hot_swap_fault_sequencer_tb;
   import hot_swap_pkg::*;
   logic clk, rst_b, reg_wr, clear_faults, alert_n, uv_ok, f_cl, f_cb, f_pw, hi_d;
   logic o_cl, o_cb, o_pw, t_hi, t_mid, t_lo;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   analog_in_t ain;
   drive_t drive;
   int fails = 0, compares = 0, hi_cnt = 0, hi_base = 0;
   // straps: limit pin high, breaker pin low, retry pin low
   assign ain = '{o_cl, o_cb, o_pw, t_hi, t_mid, t_lo, uv_ok, 1'b1, 1'b0, 1'b0};
   hot_swap_fault_sequencer dut_u (.clk(clk), .rst_b(rst_b), .analog_in(ain),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .clear_faults(clear_faults), .reg_rdata(reg_rdata), .drive(drive), .alert_n(alert_n));
   fet_timer_model fet_u (.clk(clk), .drive(drive), .fault_cl(f_cl), .fault_cb(f_cb),
      .fault_pw(f_pw), .over_limit(o_cl), .over_breaker(o_cb), .over_power(o_pw),
      .timer_hi(t_hi), .timer_mid(t_mid), .timer_lo(t_lo));
   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // count upper-level hits while the switch is off
   always @(posedge clk)
   begin
      hi_d <= t_hi;
      if (t_hi && !hi_d && drive.gate == gate_weak_pd)
         hi_cnt <= hi_cnt + 1;
   end
   task automatic give_verdict;
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      @(negedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_addr = a;
      @(negedge clk);
      rv = reg_rdata;
   endtask : rd
   task automatic pulse_clear;
      clear_faults = 1'b1;
      @(negedge clk);
      clear_faults = 1'b0;
      repeat (3) @(negedge clk);
   endtask : pulse_clear
   // bounded wait for a gate mode; running out ends the run
   task automatic wait_gate(input gate_mode_t g, input int lim);
      repeat (lim) if (drive.gate !== g) @(negedge clk);
      if (drive.gate !== g)
      begin
         chk(16'(drive.gate), 16'(g));
         give_verdict();
      end
   endtask : wait_gate
   task automatic sc_regs;
      rd(alert_suppress_adr);
      chk(rv, alert_suppress_rst);
      rd(protection_setup_adr);
      chk(rv, 16'(protection_setup_rst));
      wr(protection_setup_adr, 16'h00b0);
      rd(protection_setup_adr);
      chk(rv, 16'h00b0);
      chk(16'({drive.cl_high, drive.cb_high}), 16'h0001);
      wr(protection_setup_adr, 16'h0000);
      chk(16'({drive.cl_high, drive.cb_high}), 16'h0002);
      wr(diag_summary_adr, 16'hffff);
      rd(8'h55);
      chk(rv, 16'h0000);
   endtask : sc_regs
   task automatic sc_limit;
      wait_gate(gate_source, 1000);
      f_pw = 1'b1;
      wait_gate(gate_regulate, 20);
      chk(16'(drive.timer), 16'(tmr_fault_chg));
      f_pw = 1'b0;
      wait_gate(gate_source, 20);
      chk(16'(drive.timer), 16'(tmr_fast_dis));
   endtask : sc_limit
   task automatic sc_breaker;
      f_cb = 1'b1;
      wait_gate(gate_strong_pd, 10);
      chk(16'(drive.timer), 16'(tmr_fault_chg));
      f_cb = 1'b0;
      wait_gate(gate_source, 20);
      rd(vendor_fault_status_adr);
      chk(rv, 16'h0001);
      rd(diag_summary_adr);
      chk(rv & 16'h000f, 16'h0001);
      chk(16'(alert_n), 16'h0000);
      pulse_clear();
      chk(16'(alert_n), 16'h0001);
   endtask : sc_breaker
   task automatic sc_retry;
      wr(alert_suppress_adr, 16'h0002);
      wr(protection_setup_adr, 16'h0004);
      hi_base = hi_cnt;
      f_cl = 1'b1;
      wait_gate(gate_weak_pd, 200);
      rd(input_fault_status_adr);
      chk(rv, 16'h0002);
      rd(summary_status_adr);
      chk(rv & 16'h2000, 16'h2000);
      rd(diag_summary_adr);
      chk(rv & 16'h000f, 16'h0002);
      chk(16'(alert_n), 16'h0001);
      wait_gate(gate_source, 2000);
      chk(16'(hi_cnt - hi_base), 16'h0007);
      wait_gate(gate_weak_pd, 200);
      repeat (400) if (!t_lo) @(negedge clk);
      chk(16'(t_lo), 16'h0001);
      repeat (10) @(negedge clk);
      chk(16'({drive.gate, drive.timer}), 16'({gate_weak_pd, tmr_small_dis}));
      rd(diag_summary_adr);
      chk(rv & 16'h0008, 16'h0008);
      // enable pulse only once the timer sits below the low level
      uv_ok = 1'b0;
      repeat (6) @(negedge clk);
      uv_ok = 1'b1;
      f_cl = 1'b0;
      wait_gate(gate_source, 1000);
      rd(diag_summary_adr);
      chk(rv & 16'h0008, 16'h0000);
   endtask : sc_retry
   task automatic sc_uv;
      pulse_clear();
      uv_ok = 1'b0;
      wait_gate(gate_weak_pd, 20);
      chk(16'({drive.uv_hyst_en, drive.ov_src_en}), 16'h0002);
      rd(input_fault_status_adr);
      chk(rv, 16'h0010);
      rd(diag_summary_adr);
      chk(rv & 16'h000f, 16'h0004);
      chk(16'(alert_n), 16'h0000);
      uv_ok = 1'b1;
      wait_gate(gate_source, 1000);
      chk(16'(drive.uv_hyst_en), 16'h0000);
   endtask : sc_uv
   // main sequence
   initial
   begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      clear_faults = 1'b0;
      uv_ok = 1'b1;
      f_cl = 1'b0;
      f_cb = 1'b0;
      f_pw = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      sc_regs();
      sc_limit();
      sc_breaker();
      sc_retry();
      sc_uv();
      give_verdict();
   end
endmodule : hot_swap_fault_sequencer_tb
